/* File: bct_top.sv */
// Body control timers: lock, defogger, window, courtesy, belt and wiper
//
// Overview of operation
// - Door open, key in, driver knob locked: run unlock timer, drive unlock relay.
// - Driver knob unlocked keeps unlock gate low, whatever the passenger knob says.
// - Defogger press with ignition on and charge high starts defogger relay timer.
// - Defogger relay drops automatically after eleven minutes.
// - Second press or charge falling low releases the running defogger at once.
// - Ignition on keeps window and tension reducer enable active.
// - Ignition on-to-off holds window enable thirty seconds.
// - Door opening during that hold cancels it and drops enable immediately.
// - Courtesy switch at door position: open door lights dome, foot, cylinder.
// - Door closing with ignition off fades courtesy lights over six seconds.
// - Door closing with ignition on turns courtesy lights off immediately.
// - Ignition on runs six second belt window gated with alternating pulses.
// - Light flashes regardless of belt; buzzer only while belt unfastened.
// - Ignition off during belt window ends light and buzzer at once.
// - Buckling during the belt window stops the buzzer.
// - Ignition on or accessory with intermittent selected pulses wiper per knob interval.
// - Short washer press wipes once after a delay equal to press length.
// - Long washer press starts wiping after the threshold on-delay.
// - After washer release wiper keeps running for a further hold window.
// - Mist and washer wiping also work during intermittent, merged into one drive.
// - Every monitored switch is reflected on the diagnosis output.
`timescale 1ns/1ns
`default_nettype none
module bct_top
  import bct_pkg::*;
#(
  parameter int PRESCALE = TICK_CYCLES
) (
  input  wire logic     i_sys_clk,
  input  wire logic     i_rst_n,
  input  wire bct_sw_t  i_sw,
  output var  bct_drv_t o_drv,
  output var  bct_sw_t  o_diag
);

  // A prescale of one still needs a one-bit counter, which then ticks every cycle
  localparam int PS_W = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;

  typedef enum logic [2:0] {WS_IDLE, WS_PRESS, WS_MIST_DLY, WS_WIPE_ONE, WS_LONG,
                            WS_HOLD} bct_wash_t;

  function automatic logic [TW-1:0] bct_inc(input logic [TW-1:0] c, input logic t);
    bct_inc = t ? c + 1'b1 : c;
  endfunction

  bct_sw_t       sw;
  bct_sw_t       sw_q;
  logic [PS_W-1:0] ps_r;
  logic          tick;
  logic          run;
  logic          gate_lock;
  logic          unlock_r;
  logic [TW-1:0] unlock_cnt_r;
  logic          defog_r;
  logic [TW-1:0] defog_cnt_r;
  logic          win_r;
  logic          win_hold_r;
  logic [TW-1:0] win_cnt_r;
  logic          dim_r;
  logic [7:0]    duty_r;
  logic [7:0]    phase_r;
  logic [TW-1:0] dim_cnt_r;
  logic          cour_r;
  logic          belt_win_r;
  logic [TW-1:0] belt_cnt_r;
  logic          pulse_r;
  logic [TW-1:0] pulse_cnt_r;
  logic          light_r;
  logic          buzz_r;
  logic          int_req_r;
  logic [TW-1:0] int_cnt_r;
  logic [TW-1:0] int_lim;
  bct_wash_t     ws_r;
  logic [TW-1:0] ws_cnt_r;
  logic [TW-1:0] press_r;
  logic          wash_req;
  logic          wiper_r;

  // Time base shared by every timer and the debouncer
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ps_r <= '0;
    end else if (ps_r == PS_W'(PRESCALE - 1)) begin
      ps_r <= '0;
    end else begin
      ps_r <= ps_r + 1'b1;
    end
  end
  assign tick = (ps_r == PS_W'(PRESCALE - 1));

  bct_debounce #(.W(SW_W)) u_deb (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_tick    (tick),
    .i_raw     (i_sw),
    .o_clean   (sw)
  );

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sw_q   <= '0;
      o_diag <= '0;
    end else begin
      sw_q   <= sw;
      o_diag <= sw;
    end
  end

  // Key-left lock prevention; passenger knob alone never reaches the timer
  assign gate_lock = sw.door_open & sw.key_in & sw.drv_lock;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      unlock_r     <= 1'b0;
      unlock_cnt_r <= '0;
    end else if (gate_lock && !unlock_r && !(sw_q.door_open && sw_q.key_in && sw_q.drv_lock)) begin
      unlock_r     <= 1'b1;
      unlock_cnt_r <= '0;
    end else if (unlock_r) begin
      unlock_cnt_r <= bct_inc(unlock_cnt_r, tick);
      if (unlock_cnt_r >= UNLOCK_MS) begin
        unlock_r <= 1'b0;
      end
    end
  end

  // Defogger timer
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      defog_r     <= 1'b0;
      defog_cnt_r <= '0;
    end else if (defog_r) begin
      defog_cnt_r <= bct_inc(defog_cnt_r, tick);
      if ((sw.defog_sw && !sw_q.defog_sw) || sw.chg_lo || !sw.ign_on) begin
        defog_r <= 1'b0;
      end else if (defog_cnt_r >= DEFOG_MS) begin
        defog_r <= 1'b0;
      end
    end else if (sw.defog_sw && !sw_q.defog_sw && sw.ign_on && sw.chg_hi) begin
      defog_r     <= 1'b1;
      defog_cnt_r <= '0;
    end
  end

  // Window and tension reducer enable
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      win_hold_r <= 1'b0;
      win_cnt_r  <= '0;
      win_r      <= 1'b0;
    end else begin
      if (sw.ign_on) begin
        win_hold_r <= 1'b0;
      end else if (sw_q.ign_on) begin
        win_hold_r <= 1'b1;
        win_cnt_r  <= '0;
      end else if (win_hold_r) begin
        win_cnt_r <= bct_inc(win_cnt_r, tick);
        if ((sw.door_open && !sw_q.door_open) || win_cnt_r >= WINDOW_MS) begin
          win_hold_r <= 1'b0;
        end
      end
      win_r <= sw.ign_on | (win_hold_r & ~sw.ign_on & ~(sw.door_open & ~sw_q.door_open)
               & ~(win_cnt_r >= WINDOW_MS));
    end
  end

  // Dimming courtesy light: duty falls one step each DIM_STEP_MS
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dim_r     <= 1'b0;
      duty_r    <= '0;
      dim_cnt_r <= '0;
    end else if (sw.ign_on || (sw.door_open && sw.courtesy_door)) begin
      dim_r <= 1'b0;
    end else if (sw_q.door_open && !sw.door_open && sw.courtesy_door) begin
      dim_r     <= 1'b1;
      duty_r    <= DUTY_FULL;
      dim_cnt_r <= '0;
    end else if (dim_r && tick) begin
      if (dim_cnt_r >= DIM_STEP_MS - 1'b1) begin
        dim_cnt_r <= '0;
        if (duty_r == '0) begin
          dim_r <= 1'b0;
        end else begin
          duty_r <= duty_r - 1'b1;
        end
      end else begin
        dim_cnt_r <= dim_cnt_r + 1'b1;
      end
    end
  end

  // Lamp load is slow, so a fast free-running phase gives a smooth fade
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_r <= '0;
      cour_r  <= 1'b0;
    end else begin
      phase_r <= phase_r + 1'b1;
      cour_r  <= (sw.door_open & sw.courtesy_door)
                 | (dim_r & ~sw.ign_on & (phase_r < duty_r));
    end
  end

  // Belt warning window and pulse train
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      belt_win_r  <= 1'b0;
      belt_cnt_r  <= '0;
      pulse_r     <= 1'b0;
      pulse_cnt_r <= '0;
    end else begin
      if (!sw.ign_on) begin
        belt_win_r <= 1'b0;
      end else if (!sw_q.ign_on) begin
        belt_win_r <= 1'b1;
        belt_cnt_r <= '0;
      end else if (belt_win_r) begin
        belt_cnt_r <= bct_inc(belt_cnt_r, tick);
        if (belt_cnt_r >= BELT_MS) begin
          belt_win_r <= 1'b0;
        end
      end
      if (!belt_win_r) begin
        pulse_r     <= 1'b1;
        pulse_cnt_r <= '0;
      end else if (tick) begin
        if (pulse_cnt_r >= BELT_PULSE_MS - 1'b1) begin
          pulse_cnt_r <= '0;
          pulse_r     <= ~pulse_r;
        end else begin
          pulse_cnt_r <= pulse_cnt_r + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      light_r <= 1'b0;
      buzz_r  <= 1'b0;
    end else begin
      light_r <= belt_win_r & pulse_r & sw.ign_on;
      buzz_r  <= belt_win_r & pulse_r & sw.ign_on & sw.belt_unfastened;
    end
  end

  // Intermittent wiper
  assign run     = sw.ign_on | sw.ign_acc;
  assign int_lim = INT_BASE_MS + TW'(sw.int_knob) * INT_STEP_MS;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_req_r <= 1'b0;
      int_cnt_r <= '0;
    end else if (!(run && sw.wiper_int)) begin
      int_req_r <= 1'b0;
      int_cnt_r <= '0;
    end else if (tick) begin
      if (int_cnt_r >= int_lim) begin
        int_cnt_r <= '0;
        int_req_r <= 1'b1;
      end else begin
        int_cnt_r <= int_cnt_r + 1'b1;
        if (int_cnt_r >= WIPE_CYCLE_MS) begin
          int_req_r <= 1'b0;
        end
      end
    end
  end

  // Mist and washer-linked wiper
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ws_r     <= WS_IDLE;
      ws_cnt_r <= '0;
      press_r  <= '0;
    end else if (!run) begin
      ws_r <= WS_IDLE;
    end else begin
      unique case (ws_r)
        WS_IDLE: begin
          if (sw.washer) begin
            ws_r    <= WS_PRESS;
            press_r <= '0;
          end
        end
        WS_PRESS: begin
          press_r <= bct_inc(press_r, tick);
          if (press_r >= WASH_THR_MS) begin
            ws_r <= WS_LONG;
          end else if (!sw.washer) begin
            ws_r     <= WS_MIST_DLY;
            ws_cnt_r <= '0;
          end
        end
        WS_MIST_DLY: begin
          ws_cnt_r <= bct_inc(ws_cnt_r, tick);
          if (ws_cnt_r >= press_r) begin
            ws_r     <= WS_WIPE_ONE;
            ws_cnt_r <= '0;
          end
        end
        WS_WIPE_ONE: begin
          ws_cnt_r <= bct_inc(ws_cnt_r, tick);
          if (ws_cnt_r >= WIPE_CYCLE_MS) begin
            ws_r <= WS_IDLE;
          end
        end
        WS_LONG: begin
          if (!sw.washer) begin
            ws_r     <= WS_HOLD;
            ws_cnt_r <= '0;
          end
        end
        WS_HOLD: begin
          ws_cnt_r <= bct_inc(ws_cnt_r, tick);
          if (sw.washer) begin
            ws_r <= WS_LONG;
          end else if (ws_cnt_r >= WASH_AFTER_MS) begin
            ws_r <= WS_IDLE;
          end
        end
      endcase
    end
  end

  assign wash_req = (ws_r == WS_WIPE_ONE) | (ws_r == WS_LONG) | (ws_r == WS_HOLD);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wiper_r <= 1'b0;
    end else begin
      wiper_r <= run & (int_req_r | wash_req);
    end
  end

  assign o_drv = '{unlock: unlock_r, defog: defog_r, window_en: win_r, courtesy: cour_r,
                   belt_light: light_r, buzzer: buzz_r, wiper: wiper_r};

  chk_unlock_knob: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(unlock_r) |-> $past(gate_lock)) else $error("unlock started without knob locked");
  chk_defog_start: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(defog_r) |-> $past(sw.ign_on && sw.chg_hi)) else $error("defogger start not allowed");
  chk_defog_low: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (defog_r && sw.chg_lo) |=> !defog_r) else $error("defogger kept running with low charge");
  chk_window_ign: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    sw.ign_on |=> win_r) else $error("window enable low with ignition on");
  chk_window_door: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!sw.ign_on && $rose(sw.door_open)) ##1 !sw.ign_on |-> !win_r)
    else $error("window enable kept after door opened");
  chk_light_ign_on: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (sw.ign_on && !sw.door_open) |=> !cour_r) else $error("courtesy light on with ignition on");
  chk_belt_ign_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !sw.ign_on |=> !light_r && !buzz_r) else $error("belt warning active with ignition off");
  chk_buzz_belt: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    buzz_r |-> $past(sw.belt_unfastened) && light_r) else $error("buzzer with belt buckled");
  chk_wiper_run: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !run [*2] |-> !wiper_r) else $error("wiper driven without ignition");

  cov_defog_on: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) $rose(defog_r));
  cov_dim_fade: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    dim_r && duty_r < DUTY_FULL);
  cov_wash_hold: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ws_r == WS_HOLD && wiper_r);

endmodule
`default_nettype wire

/* File: bct_pkg.sv */
// Shared constants and carrier types for the body control timers
package bct_pkg;

  localparam int TW              = 20;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int TICK_PERIOD_NS  = 1_000_000;
  localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // Durations in their own units, then as time base ticks of 1 ms
  localparam int DEFOG_TIME_MIN  = 11;
  localparam int WINDOW_TIME_S   = 30;
  localparam int DIM_TIME_S      = 6;
  localparam int BELT_TIME_S     = 6;
  localparam int WASH_THR_TIME_MS = 600;
  localparam int WASH_AFTER_TIME_MS = 3000;

  localparam logic [TW-1:0] DEFOG_MS  = TW'(DEFOG_TIME_MIN * 60_000);
  localparam logic [TW-1:0] WINDOW_MS = TW'(WINDOW_TIME_S * 1_000);
  localparam logic [TW-1:0] DIM_MS    = TW'(DIM_TIME_S * 1_000);
  localparam logic [TW-1:0] BELT_MS   = TW'(BELT_TIME_S * 1_000);
  localparam logic [TW-1:0] WASH_THR_MS   = TW'(WASH_THR_TIME_MS);
  localparam logic [TW-1:0] WASH_AFTER_MS = TW'(WASH_AFTER_TIME_MS);
  localparam logic [TW-1:0] DIM_STEP_MS   = TW'(DIM_TIME_S * 1_000 / 256);
  localparam logic [TW-1:0] UNLOCK_MS     = 20'h003E8;
  localparam logic [TW-1:0] WIPE_CYCLE_MS = 20'h003E8;
  localparam logic [TW-1:0] BELT_PULSE_MS = 20'h001F4;
  localparam logic [TW-1:0] INT_BASE_MS   = 20'h007D0;
  localparam logic [TW-1:0] INT_STEP_MS   = 20'h003E8;
  localparam logic [TW-1:0] DEBOUNCE_MS   = 20'h0000A;
  localparam logic [7:0]    DUTY_FULL     = 8'hFF;

  typedef struct packed {
    logic       ign_on;
    logic       ign_acc;
    logic       wiper_int;
    logic [3:0] int_knob;
    logic       washer;
    logic       key_in;
    logic       door_open;
    logic       drv_lock;
    logic       pas_lock;
    logic       defog_sw;
    logic       popup_sw;
    logic       belt_unfastened;
    logic       chg_hi;
    logic       chg_lo;
    logic       courtesy_door;
  } bct_sw_t;

  localparam int SW_W = $bits(bct_sw_t);

  typedef struct packed {
    logic unlock;
    logic defog;
    logic window_en;
    logic courtesy;
    logic belt_light;
    logic buzzer;
    logic wiper;
  } bct_drv_t;

endpackage

/* File: bct_debounce.sv */
// Input synchroniser and stability filter for the switch vector
`timescale 1ns/1ns
`default_nettype none
module bct_debounce
  import bct_pkg::*;
#(
  parameter int W = SW_W
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_tick,
  input  wire logic [W-1:0] i_raw,
  output logic      [W-1:0] o_clean
);

  logic [W-1:0]  meta_r;
  logic [W-1:0]  sync_r;
  logic [W-1:0]  last_r;
  logic [TW-1:0] stable_r;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_raw;
      sync_r <= meta_r;
    end
  end

  // One shared counter: any bit moving restarts the wait for all bits
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_r   <= '0;
      stable_r <= '0;
      o_clean  <= '0;
    end else begin
      last_r <= sync_r;
      if (sync_r != last_r) begin
        stable_r <= '0;
      end else if (i_tick) begin
        if (stable_r >= DEBOUNCE_MS) begin
          o_clean <= last_r;
        end else begin
          stable_r <= stable_r + 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: bct_switch_panel.sv */
// Vehicle switch panel model feeding the body control timers
`timescale 1ns/1ns
`default_nettype none
module bct_switch_panel
  import bct_pkg::*;
(
  input  wire logic    i_sys_clk,
  input  wire bct_sw_t i_req,
  input  wire logic    i_bounce,
  output var  bct_sw_t o_sw
);
  bct_sw_t tgt;
  bct_sw_t prev;
  int      left;

  initial begin
    tgt  = '0;
    prev = '0;
    left = 0;
    o_sw = '0;
  end

  // Mechanical contacts chatter for a few cycles before settling when asked to
  always @(posedge i_sys_clk) begin
    #1;
    if (i_req !== tgt) begin
      prev = tgt;
      tgt  = i_req;
      left = i_bounce ? 6 : 0;
    end
    if (left > 0) begin
      left = left - 1;
      o_sw = left[0] ? prev : tgt;
    end else begin
      o_sw = tgt;
    end
  end
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking testbench for the body control timers
`timescale 1ns/1ns
`default_nettype none
module testbench import bct_pkg::*; ;
  // One tick per clock keeps the thirty second hold inside the run budget
  localparam int PS = 1;
  logic     sys_clk;
  logic     rst_n;
  logic     bounce;
  logic     hit;
  int       n;
  bct_sw_t  req;
  bct_sw_t  sw;
  bct_sw_t  diag;
  bct_drv_t drv;
  int       failures;
  int       n_compared;

  bct_switch_panel panel (.i_sys_clk(sys_clk), .i_req(req), .i_bounce(bounce), .o_sw(sw));
  bct_top #(.PRESCALE(PS)) uut (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_sw(sw),
                                .o_drv(drv), .o_diag(diag));

  always #5 sys_clk = ~sys_clk;

  task automatic ms(input int t);
    repeat (t * PS) @(posedge sys_clk);
    #3;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic press;
    bounce = 1'b1;
    req.defog_sw = 1'b1;
    ms(60);
    req.defog_sw = 1'b0;
    ms(60);
    bounce = 1'b0;
  endtask

  // Fraction of one full PWM period that the courtesy driver is on
  task automatic duty(output int cnt);
    cnt = 0;
    repeat (256) begin
      @(posedge sys_clk);
      #3;
      cnt += int'(drv.courtesy === 1'b1);
    end
  endtask

  task automatic wait_wiper(input logic lvl, output logic found);
    found = 1'b0;
    for (int i = 0; i < 1500 && !found; i++) begin
      ms(1);
      found = (drv.wiper === lvl);
    end
  endtask

  task automatic t_unlock;
    req.door_open = 1'b1;
    req.key_in = 1'b1;
    req.pas_lock = 1'b1;
    ms(200);
    chk("unlock knob open", 32'(drv.unlock), 32'h0);
    req.drv_lock = 1'b1;
    ms(100);
    chk("unlock start", 32'(drv.unlock), 32'h1);
    ms(800);
    chk("unlock held", 32'(drv.unlock), 32'h1);
    ms(300);
    chk("unlock end", 32'(drv.unlock), 32'h0);
    req = '0;
    ms(50);
  endtask

  task automatic t_defog;
    req.ign_on = 1'b1;
    press();
    chk("defog no charge", 32'(drv.defog), 32'h0);
    req.chg_hi = 1'b1;
    press();
    chk("defog on", 32'(drv.defog), 32'h1);
    press();
    chk("defog second press", 32'(drv.defog), 32'h0);
    press();
    chk("defog restart", 32'(drv.defog), 32'h1);
    req.chg_hi = 1'b0;
    req.chg_lo = 1'b1;
    ms(50);
    chk("defog charge low", 32'(drv.defog), 32'h0);
    req = '0;
    ms(50);
  endtask

  task automatic t_belt;
    req.belt_unfastened = 1'b1;
    req.ign_on = 1'b1;
    ms(220);
    chk("belt light first", 32'(drv.belt_light), 32'h1);
    chk("buzzer unfastened", 32'(drv.buzzer), 32'h1);
    chk("window ign on", 32'(drv.window_en), 32'h1);
    ms(500);
    chk("belt light gap", 32'(drv.belt_light), 32'h0);
    ms(500);
    req.belt_unfastened = 1'b0;
    ms(100);
    chk("buzzer buckled", 32'(drv.buzzer), 32'h0);
    chk("light buckled", 32'(drv.belt_light), 32'h1);
    ms(5000);
    chk("belt window over", 32'(drv.belt_light), 32'h0);
    req.ign_on = 1'b0;
    ms(50);
    req.ign_on = 1'b1;
    req.belt_unfastened = 1'b1;
    ms(200);
    chk("belt light again", 32'(drv.belt_light), 32'h1);
    req.ign_on = 1'b0;
    ms(50);
    chk("light ign off", 32'(drv.belt_light), 32'h0);
    chk("buzzer ign off", 32'(drv.buzzer), 32'h0);
    ms(1000);
    chk("light stays off", 32'(drv.belt_light), 32'h0);
    req = '0;
  endtask

  task automatic t_window;
    req.ign_on = 1'b1;
    ms(100);
    chk("window on", 32'(drv.window_en), 32'h1);
    req.ign_on = 1'b0;
    ms(29000);
    chk("window hold", 32'(drv.window_en), 32'h1);
    ms(1200);
    chk("window hold end", 32'(drv.window_en), 32'h0);
    req.ign_on = 1'b1;
    ms(100);
    req.ign_on = 1'b0;
    ms(1000);
    chk("window hold again", 32'(drv.window_en), 32'h1);
    req.door_open = 1'b1;
    ms(50);
    chk("window door cancel", 32'(drv.window_en), 32'h0);
    req.door_open = 1'b0;
    ms(50);
  endtask

  task automatic t_courtesy;
    req.courtesy_door = 1'b1;
    req.door_open = 1'b1;
    ms(50);
    chk("courtesy door open", 32'(drv.courtesy), 32'h1);
    req.door_open = 1'b0;
    ms(30);
    duty(n);
    chk("fade start", 32'(n > 200), 32'h1);
    ms(2700);
    duty(n);
    chk("fade middle", 32'(n > 60 && n < 200), 32'h1);
    ms(3500);
    duty(n);
    chk("fade done", 32'(n), 32'h0);
    req.ign_on = 1'b1;
    req.door_open = 1'b1;
    ms(50);
    req.door_open = 1'b0;
    ms(40);
    duty(n);
    chk("no fade ign on", 32'(n), 32'h0);
    req = '0;
    ms(50);
  endtask

  task automatic t_wiper;
    req.ign_acc = 1'b1;
    req.wiper_int = 1'b1;
    ms(1500);
    chk("int before interval", 32'(drv.wiper), 32'h0);
    wait_wiper(1'b1, hit);
    chk("int pulse", 32'(hit), 32'h1);
    req.wiper_int = 1'b0;
    wait_wiper(1'b0, hit);
    req.washer = 1'b1;
    ms(300);
    req.washer = 1'b0;
    ms(200);
    chk("mist delay", 32'(drv.wiper), 32'h0);
    ms(200);
    chk("mist wipe", 32'(drv.wiper), 32'h1);
    ms(1200);
    chk("mist single", 32'(drv.wiper), 32'h0);
    req.washer = 1'b1;
    ms(500);
    chk("wash on delay", 32'(drv.wiper), 32'h0);
    ms(200);
    chk("wash wipe", 32'(drv.wiper), 32'h1);
    ms(800);
    req.washer = 1'b0;
    ms(2500);
    chk("wash after hold", 32'(drv.wiper), 32'h1);
    ms(1600);
    chk("wash after end", 32'(drv.wiper), 32'h0);
    req.wiper_int = 1'b1;
    req.int_knob = 4'hF;
    ms(100);
    req.washer = 1'b1;
    ms(300);
    req.washer = 1'b0;
    ms(400);
    chk("mist during int", 32'(drv.wiper), 32'h1);
    req = '0;
    ms(1200);
  endtask

  task automatic t_diag;
    for (int k = 0; k < SW_W; k++) begin
      req = bct_sw_t'(SW_W'(1) << k);
      ms(40);
      chk("diag reflect", 32'(diag), 32'(req));
    end
    req = '0;
    ms(40);
  endtask

  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    bounce = 1'b0;
    req = '0;
    failures = 0;
    n_compared = 0;
    repeat (12) @(posedge sys_clk);
    #3;
    chk("drive in reset", 32'(drv), 32'h0);
    rst_n = 1'b1;
    ms(50);
    chk("drive after reset", 32'(drv), 32'h0);
    t_unlock();
    t_defog();
    t_belt();
    t_window();
    t_courtesy();
    t_wiper();
    t_diag();
    complete_run();
  end

  // Scenarios need about 61000 cycles; this leaves ample margin
  initial begin
    repeat (95000) @(posedge sys_clk);
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire
